//--- light_status_consts.svh
// constants for the light sensor status and alert control block
//
// Notes on behaviour
// - overrange flag equals the overflow of each completed measurement.
// - manual range: overrange may be set with a result below full scale.
// - auto range: overflow below top range aborts, steps range up, restarts.
// - conversion done flag sets when each conversion completes.
// - done clears on configuration register read or non-shutdown write; shutdown write keeps it.
// - above flag sets after the selected run of results above high limit.
// - below flag sets after the selected run of results below low limit.
// - latch bit 0: alert and limit flags follow the latest comparison.
// - latch bit 1, the reset value: flags and alert hold until read.
// - polarity 0, the reset value: alert drives the pin low.
// - polarity 1: alert releases the pin; an outside pull-up lifts it.
// - mask bit with manual range reads result exponent as zero.
// - masking touches only the read value; comparisons use the true exponent.
// - trip count field 00,01,10,11 selects runs of 1,2,4,8 faults.
// - flags at bits 8,7,6,5, read only, reset to zero.
// - latch bit 4, polarity 3, mask 2, trip count 1:0, all writable.
// - mode 00 shutdown, 01 single shot, 1x continuous; single shot returns to 00.
// - range code 1100b selects automatic ranging, reported in result exponent.
// - entering shutdown leaves flags and the alert pin as they were.
// - result and limits compare as mantissa times two to the exponent.
`ifndef LIGHT_STATUS_CONSTS_SVH
`define LIGHT_STATUS_CONSTS_SVH

// -----------------------------------------------------------------
// register addresses
// -----------------------------------------------------------------
`define RESULT_ADDR 8'h00
`define CFG_ADDR 8'h01
`define LOW_LIMIT_ADDR 8'h02
`define HIGH_LIMIT_ADDR 8'h03

// -----------------------------------------------------------------
// field positions and reset values
// -----------------------------------------------------------------
`define BIT_OVERRANGE 8
`define BIT_DONE 7
`define BIT_ABOVE 6
`define BIT_BELOW 5
`define BIT_LATCH 4
`define BIT_SENSE 3
`define BIT_HIDE 2
`define CFG_RESET 16'hc810
`define RANGE_AUTO 4'hc
`define RANGE_TOP 4'hb
`define RANGE_LOW 4'h0
`define MODE_SHUTDOWN 2'h0
`define MODE_SINGLE 2'h1
`define TRIP_CNT_MAX 4'h8

`endif

//--- light_status_pkg.sv
// types shared by the light sensor status and alert control block
package light_status_pkg;

  // -----------------------------------------------------------------
  // control and status register, packed in bit order 15..0
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] range_select;
    logic conv_long;
    logic [1:0] mode;
    logic overrange_hit;
    logic conversion_done;
    logic above_limit_hit;
    logic below_limit_hit;
    logic latch_style;
    logic alert_sense;
    logic hide_scale_bits;
    logic [1:0] trip_count_sel;
  } ctrl_reg_t;

  // result or limit word: exponent over a straight binary mantissa
  typedef struct packed {
    logic [3:0] exponent;
    logic [11:0] mantissa;
  } lux_word_t;

  // one report from the conversion engine
  typedef struct packed {
    logic done;
    logic overflow;
    lux_word_t value;
  } meas_t;

  // host register access strobes
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  // state of one consecutive-fault counter
  typedef struct packed {
    logic [3:0] cnt;
  } trip_state_t;

  // whole state of the main block
  typedef struct packed {
    ctrl_reg_t ctrl;
    logic [3:0] auto_range;
    lux_word_t result;
    logic [15:0] rdata;
    logic restart;
  } main_state_t;

endpackage

//--- lux_compare.sv
// magnitude comparison of two exponent and mantissa words
`timescale 1ns/1ns
module lux_compare (
  input light_status_pkg::lux_word_t lhs, // measured word
  input light_status_pkg::lux_word_t rhs, // limit word
  output logic lhs_above, // lhs magnitude larger
  output logic lhs_below // lhs magnitude smaller
);
  import light_status_pkg::*;

  logic [26:0] lhs_mag;
  logic [26:0] rhs_mag;

  // -----------------------------------------------------------------
  // scale to a common lux grid
  // -----------------------------------------------------------------
  // widened so that reserved exponents up to fifteen cannot wrap
  assign lhs_mag = {15'h0000, lhs.mantissa} << lhs.exponent;
  assign rhs_mag = {15'h0000, rhs.mantissa} << rhs.exponent;
  assign lhs_above = lhs_mag > rhs_mag;
  assign lhs_below = lhs_mag < rhs_mag;
endmodule

//--- trip_counter.sv
// counter of consecutive limit faults with selectable run length
`timescale 1ns/1ns
`include "light_status_consts.svh"
module trip_counter (
  input wire logic clock, // device clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic meas, // one completed measurement
  input wire logic fault, // that measurement breaks the limit
  input wire logic [1:0] sel, // run length select
  output logic trip // run reached on this measurement
);
  import light_status_pkg::*;

  trip_state_t q;
  trip_state_t d;
  logic [3:0] need;
  logic [3:0] next_cnt;

  // -----------------------------------------------------------------
  // run length decode and count
  // -----------------------------------------------------------------
  // count saturates so an ongoing run keeps tripping every measurement
  always_comb begin
    d = q;
    need = 4'h1 << sel;
    next_cnt = (q.cnt == `TRIP_CNT_MAX) ? q.cnt : q.cnt + 4'h1;
    trip = meas && fault && (next_cnt >= need);
    if (meas) begin
      d.cnt = fault ? next_cnt : 4'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

//--- light_status_and_alert_control.sv
// status flags, alert pin and control register of the light sensor
`timescale 1ns/1ns
`include "light_status_consts.svh"
module light_status_and_alert_control (
  input wire logic clock, // device clock, 25 MHz
  input wire logic reset_n, // synchronous reset, active low
  input light_status_pkg::reg_req_t req, // decoded host register access
  output logic [15:0] reg_rdata, // read data, held until next read
  input light_status_pkg::meas_t meas, // engine report, done is a pulse
  input light_status_pkg::lux_word_t low_limit, // low limit register value
  input light_status_pkg::lux_word_t high_limit, // high limit register value
  output logic [3:0] range_cmd, // range the engine must convert at
  output logic conv_run, // engine may convert
  output logic conv_long, // long conversion time selected
  output logic conv_restart, // pulse: abort and restart at range_cmd
  input wire logic alert_in, // alert pin level seen
  output logic alert_out, // alert pin drive level
  output logic alert_oe // alert pin driven while high
);
  import light_status_pkg::*;

  main_state_t q;
  main_state_t d;
  logic auto_mode;
  logic running;
  logic abort;
  logic finish;
  logic cfg_rd;
  logic cfg_wr;
  logic res_rd;
  logic above_now;
  logic below_now;
  logic above_trip;
  logic below_trip;
  logic alert;
  ctrl_reg_t wr_ctrl;
  lux_word_t read_result;
  lux_word_t cmp_word;

  // -----------------------------------------------------------------
  // limit comparison on the unmasked measurement
  // -----------------------------------------------------------------
  // compared before any masking, with the exponent of the range used
  lux_compare u_cmp_high (
    .lhs(cmp_word),
    .rhs(high_limit),
    .lhs_above(above_now),
    .lhs_below()
  );

  lux_compare u_cmp_low (
    .lhs(cmp_word),
    .rhs(low_limit),
    .lhs_above(),
    .lhs_below(below_now)
  );

  // -----------------------------------------------------------------
  // consecutive fault runs, one per limit
  // -----------------------------------------------------------------
  trip_counter u_trip_high (
    .clock(clock),
    .reset_n(reset_n),
    .meas(finish),
    .fault(above_now),
    .sel(q.ctrl.trip_count_sel),
    .trip(above_trip)
  );

  trip_counter u_trip_low (
    .clock(clock),
    .reset_n(reset_n),
    .meas(finish),
    .fault(below_now),
    .sel(q.ctrl.trip_count_sel),
    .trip(below_trip)
  );

  // -----------------------------------------------------------------
  // decode of host access and engine events
  // -----------------------------------------------------------------
  assign cfg_rd = req.rd && (req.addr == `CFG_ADDR);
  assign cfg_wr = req.wr && (req.addr == `CFG_ADDR);
  assign res_rd = req.rd && (req.addr == `RESULT_ADDR);
  assign wr_ctrl = ctrl_reg_t'(req.wdata);
  assign auto_mode = q.ctrl.range_select == `RANGE_AUTO;
  assign running = q.ctrl.mode != `MODE_SHUTDOWN;
  // late reports after a shutdown are dropped so flags stay put
  assign abort = running && meas.done && meas.overflow && auto_mode
    && (q.auto_range < `RANGE_TOP);
  assign finish = running && meas.done && !abort;

  // -----------------------------------------------------------------
  // read value of the result register
  // -----------------------------------------------------------------
  always_comb begin
    read_result = q.result;
    if (q.ctrl.hide_scale_bits && (q.ctrl.range_select < `RANGE_AUTO)) begin
      read_result.exponent = 4'h0;
    end
  end

  // -----------------------------------------------------------------
  // comparison word on the true lux scale
  // -----------------------------------------------------------------
  // the engine exponent means nothing in auto ranging, so the stepped range goes in
  always_comb begin
    cmp_word = meas.value;
    if (auto_mode) begin
      cmp_word.exponent = q.auto_range;
    end
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    d = q;
    d.restart = 1'b0;
    // range stepping during automatic ranging
    if (abort) begin
      d.auto_range = q.auto_range + 4'h1;
      d.restart = 1'b1;
    end
    // completed measurement updates the status fields
    if (finish) begin
      d.result = meas.value;
      if (auto_mode) begin
        d.result.exponent = q.auto_range;
      end
      d.auto_range = `RANGE_LOW;
      d.ctrl.overrange_hit = meas.overflow;
      if (q.ctrl.mode == `MODE_SINGLE) begin
        d.ctrl.mode = `MODE_SHUTDOWN;
      end
    end
    // host write: only the writable fields move
    if (cfg_wr) begin
      d.ctrl.range_select = wr_ctrl.range_select;
      d.ctrl.conv_long = wr_ctrl.conv_long;
      d.ctrl.mode = wr_ctrl.mode;
      d.ctrl.latch_style = wr_ctrl.latch_style;
      d.ctrl.alert_sense = wr_ctrl.alert_sense;
      d.ctrl.hide_scale_bits = wr_ctrl.hide_scale_bits;
      d.ctrl.trip_count_sel = wr_ctrl.trip_count_sel;
      d.auto_range = `RANGE_LOW;
    end
    // done flag: clear by access, a new completion wins over the clear
    if (cfg_rd || (cfg_wr && (wr_ctrl.mode != `MODE_SHUTDOWN))) begin
      d.ctrl.conversion_done = 1'b0;
    end
    if (finish) begin
      d.ctrl.conversion_done = 1'b1;
    end
    // limit flags in the two reporting styles
    if (q.ctrl.latch_style) begin
      if (cfg_rd) begin
        d.ctrl.above_limit_hit = 1'b0;
        d.ctrl.below_limit_hit = 1'b0;
      end
      if (above_trip) begin
        d.ctrl.above_limit_hit = 1'b1;
      end
      if (below_trip) begin
        d.ctrl.below_limit_hit = 1'b1;
      end
    end else if (finish) begin
      d.ctrl.above_limit_hit = above_trip;
      d.ctrl.below_limit_hit = below_trip;
    end
    // read data is captured from the state before this cycle's changes
    if (cfg_rd) begin
      d.rdata = q.ctrl;
    end else if (res_rd) begin
      d.rdata = read_result;
    end else if (req.rd) begin
      d.rdata = 16'h0000;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      q.ctrl <= ctrl_reg_t'(`CFG_RESET);
      q.auto_range <= `RANGE_LOW;
      q.result <= '0;
      q.rdata <= 16'h0000;
      q.restart <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign reg_rdata = q.rdata;
  assign range_cmd = auto_mode ? q.auto_range : q.ctrl.range_select;
  assign conv_run = running;
  assign conv_long = q.ctrl.conv_long;
  assign conv_restart = q.restart;
  // the pin only ever pulls low; high comes from the outside pull-up
  assign alert = q.ctrl.above_limit_hit || q.ctrl.below_limit_hit;
  assign alert_out = 1'b0;
  assign alert_oe = alert ^ q.ctrl.alert_sense;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  sequence s_abort;
    (abort && !cfg_wr) ##1 conv_restart;
  endsequence

  sequence s_range_stepped;
    range_cmd == ($past(range_cmd) + 4'h1);
  endsequence

  // a host write in the abort cycle restarts the search, so it is left out
  a_auto_step: assert property (s_abort |-> s_range_stepped
    and $stable(q.ctrl.overrange_hit))
    else $error("auto range abort did not step the range");

  // at the top range there is nothing left to step to, so the report finishes
  sequence s_top_overflow;
    running && meas.done && meas.overflow && auto_mode
      && (q.auto_range == `RANGE_TOP) && !cfg_wr;
  endsequence

  sequence s_top_reported;
    q.ctrl.overrange_hit && (q.result.exponent == `RANGE_TOP);
  endsequence

  a_top_finish: assert property (s_top_overflow |=> s_top_reported)
    else $error("top range overflow not reported");

  a_restart_cause: assert property (conv_restart |-> $past(abort))
    else $error("restart pulse without an abort");

  // a new auto setting always starts its search at the lowest range
  a_auto_start: assert property (cfg_wr
    && (wr_ctrl.range_select == `RANGE_AUTO) |=> range_cmd == `RANGE_LOW)
    else $error("auto ranging did not restart at the lowest range");

  a_overrange_eval: assert property (finish
    |=> q.ctrl.overrange_hit == $past(meas.overflow))
    else $error("overrange flag not equal to last overflow");

  // -----------------------------------------------------------------
  // checks on the done flag, the mode, the limit flags, the written fields, the alert pin and read data
  // -----------------------------------------------------------------
  a_done_sets: assert property (finish |=> q.ctrl.conversion_done)
    else $error("done flag not set after completion");

  // the read word must still show the flag as it was before the clear
  a_done_read_clr: assert property (cfg_rd && !finish
    |=> !q.ctrl.conversion_done && (reg_rdata == $past(q.ctrl)))
    else $error("done flag not cleared by read");

  a_done_wr_clr: assert property (cfg_wr && !finish
    && (wr_ctrl.mode != `MODE_SHUTDOWN) |=> !q.ctrl.conversion_done)
    else $error("done flag not cleared by a running write");

  a_done_shut_keep: assert property (cfg_wr && !cfg_rd && !finish
    && (wr_ctrl.mode == `MODE_SHUTDOWN)
    |=> $stable(q.ctrl.conversion_done))
    else $error("shutdown write changed done flag");

  a_single_return: assert property (finish && !cfg_wr
    && (q.ctrl.mode == `MODE_SINGLE) |=> !conv_run ##1 !conv_run)
    else $error("single shot did not return to shutdown");

  // while shut down, late engine reports and idle cycles move nothing
  a_shut_hold: assert property (!running && !cfg_rd && !cfg_wr
    |=> $stable(q.ctrl.overrange_hit) && $stable(q.ctrl.conversion_done)
    && $stable(q.ctrl.above_limit_hit) && $stable(q.ctrl.below_limit_hit)
    && $stable(alert_oe))
    else $error("shutdown moved a flag or the alert pin");

  a_above_sets: assert property (q.ctrl.latch_style && above_trip
    |=> q.ctrl.above_limit_hit)
    else $error("latched above flag not set by its run");

  a_below_sets: assert property (q.ctrl.latch_style && below_trip
    |=> q.ctrl.below_limit_hit)
    else $error("latched below flag not set by its run");

  a_latch_hold: assert property (q.ctrl.latch_style && q.ctrl.above_limit_hit
    && !cfg_rd |=> q.ctrl.above_limit_hit)
    else $error("latched above flag dropped without read");

  a_below_hold: assert property (q.ctrl.latch_style && q.ctrl.below_limit_hit
    && !cfg_rd |=> q.ctrl.below_limit_hit)
    else $error("latched below flag dropped without read");

  a_follow_cmp: assert property (!q.ctrl.latch_style && finish
    |=> q.ctrl.below_limit_hit == $past(below_trip))
    else $error("transparent below flag does not follow comparison");

  a_follow_above: assert property (!q.ctrl.latch_style && finish
    |=> q.ctrl.above_limit_hit == $past(above_trip))
    else $error("transparent above flag does not follow comparison");

  // a single fault is enough when the shortest run is chosen
  a_count_one: assert property (finish && above_now
    && (q.ctrl.trip_count_sel == 2'h0) |-> above_trip)
    else $error("single fault count did not trip");

  // host writes leave the overrange and limit status bits alone
  a_flags_ro: assert property (cfg_wr && !cfg_rd && !finish
    |=> $stable(q.ctrl.overrange_hit) && $stable(q.ctrl.above_limit_hit)
    && $stable(q.ctrl.below_limit_hit))
    else $error("host write moved a read only flag");

  a_wr_fields: assert property (cfg_wr
    |=> (q.ctrl.latch_style == $past(wr_ctrl.latch_style))
    && (q.ctrl.alert_sense == $past(wr_ctrl.alert_sense))
    && (q.ctrl.hide_scale_bits == $past(wr_ctrl.hide_scale_bits))
    && (q.ctrl.trip_count_sel == $past(wr_ctrl.trip_count_sel)))
    else $error("writable field did not take the written value");

  a_alert_drive: assert property (q.ctrl.latch_style && above_trip
    |=> alert_oe == !q.ctrl.alert_sense)
    else $error("alert pin not asserted with its polarity");

  a_sense_idle: assert property (!q.ctrl.above_limit_hit
    && !q.ctrl.below_limit_hit |-> alert_oe == q.ctrl.alert_sense)
    else $error("idle alert pin level wrong for its polarity");

  a_mask_exp: assert property (res_rd && q.ctrl.hide_scale_bits
    && (q.ctrl.range_select < `RANGE_AUTO) |=> reg_rdata[15:12] == 4'h0)
    else $error("result exponent not masked");

  // in auto ranging the exponent is the range used and is never hidden
  a_auto_unmasked: assert property (res_rd
    && (q.ctrl.range_select == `RANGE_AUTO) |=> reg_rdata == $past(q.result))
    else $error("auto range result read altered");

  // read data stands until the next read strobe
  a_rdata_hold: assert property (!req.rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");

endmodule

//--- engine_model.sv
// conversion engine and alert pin pull-up facing the status block
`timescale 1ns/1ns
module engine_model (
  input wire logic clock, // device clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic go, // pulse: one conversion ends now
  input wire logic ovf, // that conversion overflowed
  input light_status_pkg::lux_word_t level, // value that conversion produced
  input wire logic alert_oe, // block pulls the pin
  input wire logic alert_out, // level the block drives
  output light_status_pkg::meas_t meas, // report to the block
  output logic alert_pin // resolved pin level
);
  import light_status_pkg::*;

  // -----------------------------------------------------------------
  // engine report
  // -----------------------------------------------------------------
  // a report stands one cycle; in between the fields toggle so stale data never looks valid
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      meas <= '0;
    end else if (go) begin
      meas <= {1'b1, ovf, level};
    end else begin
      meas <= {1'b0, ~meas.overflow, ~meas.value};
    end
  end

  // -----------------------------------------------------------------
  // pin
  // -----------------------------------------------------------------
  // open drain with an outside pull-up: a released pin reads high
  assign alert_pin = alert_oe ? alert_out : 1'b1;
endmodule

//--- tb_top.sv
// self-checking bench for the light status and alert control block
`timescale 1ns/1ns
`include "light_status_consts.svh"
module tb_top;
  import light_status_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  reg_req_t req = '0;
  lux_word_t low_limit = 16'h0000;
  lux_word_t high_limit = 16'hbfff;
  logic go = 1'b0;
  logic ovf = 1'b0;
  lux_word_t level = 16'h0000;
  logic [15:0] reg_rdata;
  meas_t meas;
  logic [3:0] range_cmd;
  logic conv_run, conv_long, conv_restart, alert_out, alert_oe, alert_pin;
  logic seen_restart;
  logic [3:0] seen_range;
  logic [15:0] d;
  int n_fail = 0;
  int tests_run = 0;

  always #20 clock = ~clock;

  light_status_and_alert_control light_status_and_alert_control_inst (
    .clock(clock), .reset_n(reset_n), .req(req), .reg_rdata(reg_rdata), .meas(meas),
    .low_limit(low_limit), .high_limit(high_limit), .range_cmd(range_cmd),
    .conv_run(conv_run), .conv_long(conv_long), .conv_restart(conv_restart),
    .alert_in(alert_pin), .alert_out(alert_out), .alert_oe(alert_oe)
  );
  engine_model engine_model_inst (
    .clock(clock), .reset_n(reset_n), .go(go), .ovf(ovf), .level(level),
    .alert_oe(alert_oe), .alert_out(alert_out), .meas(meas), .alert_pin(alert_pin)
  );

  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [7:0] addr, input logic [15:0] data);
    @(posedge clock);
    req <= {1'b0, 1'b1, addr, data};
    @(posedge clock);
    req <= '0;
  endtask

  // read data lands on the edge after the strobe, so sample just past it
  task automatic reg_read(input logic [7:0] addr, output logic [15:0] data);
    @(posedge clock);
    req <= {1'b1, 1'b0, addr, 16'h0000};
    @(posedge clock);
    req <= '0;
    #1 data = reg_rdata;
  endtask

  // one conversion; the restart pulse and range are caught the cycle after the report
  task automatic convert(input logic ov, input logic [15:0] val);
    @(posedge clock);
    go <= 1'b1;
    ovf <= ov;
    level <= val;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    #1 seen_restart = conv_restart;
    seen_range = range_cmd;
    @(posedge clock);
  endtask

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_reset();
    reg_read(`CFG_ADDR, d);
    check("cfg reset", `CFG_RESET, d);
    check("alert idle", 16'h1, 16'(alert_pin));
    reg_read(8'h05, d);
    check("unmapped read", 16'h0000, d);
  endtask

  task automatic t_fields();
    reg_write(`CFG_ADDR, 16'h0bff);
    reg_read(`CFG_ADDR, d);
    check("cfg write", 16'h0a1f, d);
    check("run single", 16'h1, 16'(conv_run));
    check("long time", 16'h1, 16'(conv_long));
    reg_write(`CFG_ADDR, 16'h0010);
  endtask

  task automatic t_done();
    reg_write(`CFG_ADDR, 16'h0410);
    convert(1'b0, 16'h0100);
    reg_read(`CFG_ADDR, d);
    check("done set", 16'h1, 16'(d[7]));
    check("short time", 16'h0, 16'(conv_long));
    reg_read(`CFG_ADDR, d);
    check("done read clear", 16'h0, 16'(d[7]));
    convert(1'b0, 16'h0100);
    reg_write(`CFG_ADDR, 16'h0010);
    reg_read(`CFG_ADDR, d);
    check("done kept", 16'h1, 16'(d[7]));
    reg_write(`CFG_ADDR, 16'h0210);
    convert(1'b0, 16'h0100);
    reg_read(`CFG_ADDR, d);
    check("single mode back", 16'h0, 16'(d[10:9]));
    check("single done", 16'h1, 16'(d[7]));
    check("single stops", 16'h0, 16'(conv_run));
  endtask

  task automatic t_ovf();
    reg_write(`CFG_ADDR, 16'h0610);
    convert(1'b1, 16'h0100);
    reg_read(`CFG_ADDR, d);
    check("ovf manual", 16'h1, 16'(d[8]));
    check("run mode 11", 16'h1, 16'(conv_run));
    convert(1'b0, 16'h0100);
    reg_read(`CFG_ADDR, d);
    check("ovf clears", 16'h0, 16'(d[8]));
  endtask

  task automatic t_auto();
    reg_write(`CFG_ADDR, 16'hc410);
    convert(1'b1, 16'h0100);
    check("abort restart", 16'h1, 16'(seen_restart));
    check("abort range", 16'h1, 16'(seen_range));
    reg_read(`CFG_ADDR, d);
    check("abort no ovf", 16'h0, 16'(d[8]));
    convert(1'b0, 16'h0234);
    check("no restart", 16'h0, 16'(seen_restart));
    reg_read(`RESULT_ADDR, d);
    check("auto exponent", 16'h1234, d);
    for (int r = 1; r <= 11; r++) begin
      convert(1'b1, 16'h0fff);
      check("step range", 16'(r), 16'(seen_range));
    end
    convert(1'b1, 16'h0fff);
    check("top no restart", 16'h0, 16'(seen_restart));
    reg_read(`CFG_ADDR, d);
    check("top ovf", 16'h1, 16'(d[8]));
    reg_read(`RESULT_ADDR, d);
    check("top result", 16'hbfff, d);
  endtask

  // transparent style: the above flag rises and the pin falls exactly on the nth fault
  task automatic t_trip();
    int n;
    @(posedge clock) high_limit <= 16'h0080;
    for (int s = 0; s < 4; s++) begin
      reg_write(`CFG_ADDR, 16'h0400 | 16'(s));
      convert(1'b0, 16'h0040);
      n = 1 << s;
      for (int i = 1; i <= n; i++) begin
        convert(1'b0, 16'h0100);
        reg_read(`CFG_ADDR, d);
        check("above run", 16'(i == n), 16'(d[6]));
        check("pin low", 16'(i != n), 16'(alert_pin));
      end
      convert(1'b0, 16'h0040);
      reg_read(`CFG_ADDR, d);
      check("above follows", 16'h0, 16'(d[6]));
    end
    @(posedge clock) high_limit <= 16'hbfff;
  endtask

  task automatic t_latch();
    @(posedge clock) low_limit <= 16'h0080;
    reg_write(`CFG_ADDR, 16'h0410);
    convert(1'b0, 16'h0010);
    convert(1'b0, 16'h0100);
    check("pin held", 16'h0, 16'(alert_pin));
    reg_read(`CFG_ADDR, d);
    check("below held", 16'h1, 16'(d[5]));
    reg_read(`CFG_ADDR, d);
    check("below cleared", 16'h0, 16'(d[5]));
    reg_write(`CFG_ADDR, 16'h0418);
    #1 check("inverted idle", 16'h0, 16'(alert_pin));
    convert(1'b0, 16'h0010);
    check("inverted alert", 16'h1, 16'(alert_pin));
    @(posedge clock) low_limit <= 16'h0000;
  endtask

  // masked exponent on read, yet 0x123 at range 2 still beats a limit of 0x200
  task automatic t_mask();
    @(posedge clock) high_limit <= 16'h0200;
    reg_write(`CFG_ADDR, 16'h2414);
    convert(1'b0, 16'h2123);
    reg_read(`RESULT_ADDR, d);
    check("masked result", 16'h0123, d);
    reg_read(`CFG_ADDR, d);
    check("true compare", 16'h1, 16'(d[6]));
    @(posedge clock) high_limit <= 16'hbfff;
  endtask

  // -----------------------------------------------------------------
  // verdict and run control
  // -----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks run %0d, failed %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // the whole sequence needs well under a thousand cycles
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end

  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    t_reset();
    t_fields();
    t_done();
    t_ovf();
    t_auto();
    t_trip();
    t_latch();
    t_mask();
    print_verdict();
  end
endmodule
